// File: verilog/vgsd_top.sv
// Settings and gain registers of a dual-channel gain amplifier
//
// Contract
// [R1] Settings [1:0] hold amplifier bias, default 01.
// [R2] Settings [3:2] hold output driver bias, default 01.
// [R3] Settings bit 4, default 1, picks the 50 ohm input.
// [R4] Settings bit 5, default 0, picks serial gain over pins.
// [R5] Settings bit 6 bypasses the decoder, serial source only.
// [R6] Settings bit 7 bypasses the deglitcher for both sources.
// [R7] Decoded gain bits [6:0] are 0.5 dB units up to 40 dB.
// [R8] Raw gain uses bits [8:0]; upper four stages 1/3, low five 2.
// [R9] Raw bits 7..5 select stage one 0, 10 or 20 dB.
// [R10] Raw bit 8 selects stage three 0 or 10 dB.
// [R11] Raw low five bits set stage two in 0.5 dB steps.
// [R12] Pin source selected means serial gain register is ignored.
// [R13] Pin gain words always pass through the decoder.
// [R14] Frame is 24 data, 5 address, 3 chip bits, stored on select rise.
// [R15] Controller drives pin gain codes with limited rate and skew.
// [R16] Unused register bits ignore writes and read back zero.
// [R17] Power-on and soft reset restore all field defaults; soft reset here leaves the control register as written.
module vgsd_top
    import vgsd_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       sck,
    input  wire logic       serial_select_n,
    input  wire logic       sdi,
    output logic            sdo,
    output logic            sdo_oe,
    input  wire logic [6:0] parallel_level_pins,
    output logic      [1:0] opamp_bias,
    output logic      [1:0] driver_bias,
    output logic            low_input_impedance_choice,
    output logic      [2:0] stage1_sel,
    output logic      [4:0] stage2_step,
    output logic            stage3_on
);

    // ========================================================
    // Declarations
    logic [5:0]  bit_cnt_q;
    logic [30:0] shift_q;
    logic [31:0] out_shift_q;
    logic        sdo_q;
    logic [31:0] hold_q;
    logic        done_tgl_q;
    logic        sen_s1_q, sen_s2_q, sen_s3_q;
    logic        tgl_s1_q, tgl_s2_q, tgl_s3_q;
    logic        pending_q;
    logic [6:0]  pin_s1_q, pin_s2_q;
    logic [5:0]  ctl_q;
    logic [7:0]  set_q;
    logic [8:0]  gain_q;
    logic [31:0] rd_word_q;
    logic [8:0]  dec_word;
    logic [8:0]  stage_q;

    function automatic logic [23:0] vgsd_read(input logic [4:0] a,
                                             input logic [5:0] c,
                                             input logic [7:0] s,
                                             input logic [8:0] g);
        unique case (a)
            REG_CTL:  vgsd_read = {18'h0, c};
            REG_SET:  vgsd_read = {16'h0000, s};
            REG_GAIN: vgsd_read = {15'h0, g};
            default:  vgsd_read = 24'h000000;
        endcase
    endfunction

    // Gain in half-dB units carried by a stage word
    function automatic logic [7:0] vgsd_sum(input logic [8:0] w);
        logic [7:0] t;
        t = {3'h0, w[4:0]};
        if (w[RAW_S3_BIT]) t = t + 8'h14;
        if (w[RAW_S1_LSB+1]) t = t + 8'h14;
        if (w[RAW_S1_LSB+2]) t = t + 8'h28;
        vgsd_sum = t;
    endfunction

    // ========================================================
    // Link side, clocked by the serial clock
    // The select line doubles as reset so each frame starts at bit 0
    wire link_rst_n = rst_n & ~serial_select_n;
    wire last_bit   = (bit_cnt_q == LAST_BIT);
    wire in_frame   = (bit_cnt_q < DONE_CNT);

    always_ff @(posedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_q <= 6'h00;
            shift_q   <= 31'h0;
        end else if (in_frame) begin // see [R14]
            bit_cnt_q <= bit_cnt_q + 6'h01;
            shift_q   <= {shift_q[29:0], sdi};
        end
    end

    // Readback word is quasi-static: it only moves on a commit,
    // which lands a few system cycles after the select line rises
    always_ff @(posedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            out_shift_q <= 32'h00000000;
            sdo_q       <= 1'b0;
        end else if (bit_cnt_q == 6'h00) begin
            out_shift_q <= {rd_word_q[30:0], 1'b0};
            sdo_q       <= rd_word_q[31];
        end else if (in_frame) begin
            out_shift_q <= {out_shift_q[30:0], 1'b0};
            sdo_q       <= out_shift_q[31];
        end
    end

    // Hold register survives the select line; only a full frame moves it
    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            hold_q     <= 32'h00000000;
            done_tgl_q <= 1'b0;
        end else if (!serial_select_n && last_bit) begin // see [R14]
            hold_q     <= {shift_q, sdi};
            done_tgl_q <= ~done_tgl_q;
        end
    end

    assign sdo    = sdo_q;
    assign sdo_oe = rst_n & ~serial_select_n;

    // ========================================================
    // Crossing into the system clock
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sen_s1_q <= 1'b1;
            sen_s2_q <= 1'b1;
            sen_s3_q <= 1'b1;
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
            pin_s1_q <= 7'h00;
            pin_s2_q <= 7'h00;
        end else begin
            sen_s1_q <= serial_select_n;
            sen_s2_q <= sen_s1_q;
            sen_s3_q <= sen_s2_q;
            tgl_s1_q <= done_tgl_q;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
            pin_s1_q <= parallel_level_pins; // see [R15]
            pin_s2_q <= pin_s1_q;
        end
    end

    wire sen_rise  = sen_s2_q & ~sen_s3_q;
    wire new_frame = tgl_s2_q ^ tgl_s3_q;
    wire commit    = sen_rise & (pending_q | new_frame);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_q <= 1'b0;
        end else if (commit) begin
            pending_q <= 1'b0;
        end else if (new_frame) begin
            pending_q <= 1'b1;
        end
    end

    // ========================================================
    // Register file
    wire [23:0] wr_data  = hold_q[DATA_MSB:DATA_LSB];
    wire [4:0]  wr_addr  = hold_q[ADDR_MSB:ADDR_LSB];
    wire        chip_ok  = (hold_q[2:0] == CHIP_ID);
    wire        wr_en    = commit & chip_ok; // see [R14]
    wire        srst     = ctl_q[CTL_SRST_BIT];
    wire        wr_ctl   = wr_en & (wr_addr == REG_CTL);
    wire        wr_set   = wr_en & (wr_addr == REG_SET);
    wire        wr_gain  = wr_en & (wr_addr == REG_GAIN);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= CTL_DEFAULT;
        end else if (wr_ctl) begin
            ctl_q <= wr_data[CTL_W-1:0];
        end
    end

    // Soft reset holds the fields at default until the bit is cleared
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            set_q  <= SET_DEFAULT; // see [R17]
            gain_q <= GAIN_DEFAULT;
        end else if (srst) begin
            set_q  <= SET_DEFAULT; // see [R17]
            gain_q <= GAIN_DEFAULT;
        end else begin
            if (wr_set) set_q <= wr_data[SET_W-1:0]; // see [R16]
            if (wr_gain) gain_q <= wr_data[GAIN_W-1:0]; // see [R16]
        end
    end

    wire [4:0] rd_addr = ctl_q[4:0];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_word_q <= 32'h00000000;
        end else begin
            rd_word_q <= {vgsd_read(rd_addr, ctl_q, set_q, gain_q),
                          rd_addr, CHIP_ID};
        end
    end

    // ========================================================
    // Gain path
    wire       use_serial = set_q[SET_SRC_BIT]; // see [R4]
    wire       raw_mode   = use_serial & set_q[SET_RAW_BIT]; // see [R5]
    wire       dgl_bypass = set_q[SET_DGL_BIT];
    // Pins ignore the raw bit and always decode
    wire [6:0] dec_code   =
        use_serial ? gain_q[CODE_W-1:0] : pin_s2_q; // see [R12] see [R13]
    wire [8:0] stage_word = raw_mode ? gain_q : dec_word; // see [R8]

    vgsd_gain_decoder u_decoder (
        .code       (dec_code),
        .stage_word (dec_word)
    );

    vgsd_deglitch #(
        .WIDTH  (GAIN_W),
        .CYCLES (DGL_CYCLES)
    ) u_deglitch (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .bypass  (dgl_bypass), // see [R6]
        .word_in (stage_word),
        .word_q  (stage_q)
    );

    // ========================================================
    // Outputs
    assign opamp_bias  = set_q[SET_OPAMP_LSB+1:SET_OPAMP_LSB]; // see [R1]
    assign driver_bias = set_q[SET_DRVR_LSB+1:SET_DRVR_LSB]; // see [R2]
    assign low_input_impedance_choice = set_q[SET_RIN_BIT]; // see [R3]
    assign stage1_sel  = stage_q[RAW_S1_LSB+2:RAW_S1_LSB]; // see [R9]
    assign stage2_step = stage_q[4:0]; // see [R11]
    assign stage3_on   = stage_q[RAW_S3_BIT]; // see [R10]

    // ========================================================
    // Checks
    sequence frame_commit_s;
        sen_rise && (pending_q || new_frame) && chip_ok;
    endsequence

    sequence set_write_s;
        frame_commit_s ##0 (wr_addr == REG_SET) ##0 !srst;
    endsequence

    sequence gain_write_s;
        frame_commit_s ##0 (wr_addr == REG_GAIN) ##0 !srst;
    endsequence

    settings_store_a: assert property ( // see [R1]
        @(posedge sys_clk) disable iff (!rst_n)
        set_write_s |=> (set_q == $past(wr_data[7:0]))
                        && (opamp_bias == $past(wr_data[1:0]))
                        && (driver_bias == $past(wr_data[3:2]))
    ) else $error("settings write not stored");

    gain_store_a: assert property ( // see [R16]
        @(posedge sys_clk) disable iff (!rst_n)
        gain_write_s |=> (rd_word_q[31:17] == 15'h0
                          || rd_addr != REG_GAIN)
                         && gain_q == $past(wr_data[8:0])
    ) else $error("gain write wrong or upper bits kept");

    soft_reset_a: assert property ( // see [R17]
        @(posedge sys_clk) disable iff (!rst_n)
        srst |=> (set_q == SET_DEFAULT) && (gain_q == GAIN_DEFAULT)
                 && low_input_impedance_choice
    ) else $error("soft reset did not restore defaults");

    wrong_chip_a: assert property ( // see [R14]
        @(posedge sys_clk) disable iff (!rst_n)
        (commit && !chip_ok && !srst) |=> $stable(set_q) && $stable(gain_q)
    ) else $error("frame for another chip was stored");

    pin_source_a: assert property ( // see [R12]
        @(posedge sys_clk) disable iff (!rst_n)
        !use_serial |-> (dec_code == pin_s2_q) && (stage_word == dec_word)
    ) else $error("serial gain leaked into pin source");

    raw_path_a: assert property ( // see [R8]
        @(posedge sys_clk) disable iff (!rst_n)
        raw_mode |-> stage_word == gain_q
    ) else $error("raw mode not passing gain register");

    decode_sum_a: assert property ( // see [R7]
        @(posedge sys_clk) disable iff (!rst_n)
        !raw_mode |-> vgsd_sum(stage_word) ==
            ((dec_code > CODE_MAX) ? {1'b0, CODE_MAX} : {1'b0, dec_code})
    ) else $error("decoded stage gain does not match code");

    bypass_pass_a: assert property ( // see [R6]
        @(posedge sys_clk) disable iff (!rst_n)
        dgl_bypass ##1 dgl_bypass |-> stage_q == $past(stage_word)
    ) else $error("bypassed deglitcher delayed the word");

    deglitch_hold_a: assert property ( // see [R6]
        @(posedge sys_clk) disable iff (!rst_n)
        (!dgl_bypass && $changed(stage_word)) ##1 !dgl_bypass
            |-> $stable(stage_q)
    ) else $error("deglitcher passed an unsettled word");

    // Checked at the next frame's first edge; the select line resets
    // the link logic in between, so only the system reset disables it
    frame_toggle_a: assert property ( // see [R14]
        @(posedge sck) disable iff (!rst_n)
        (last_bit && !serial_select_n)
            |=> (done_tgl_q != $past(done_tgl_q))
                && hold_q[31:1] == $past(shift_q)
    ) else $error("frame end did not publish the word");

    sdo_first_a: assert property ( // see [R14]
        @(posedge sck) disable iff (!link_rst_n)
        (bit_cnt_q == 6'h00) |=> sdo == $past(rd_word_q[31])
    ) else $error("readback did not start with the top bit");

    stage_onehot_a: assert property ( // see [R9]
        @(posedge sys_clk) disable iff (!rst_n)
        !raw_mode |-> $onehot(stage_word[RAW_S1_LSB+2:RAW_S1_LSB])
    ) else $error("decoded stage one is not a single setting");

    step_limit_a: assert property ( // see [R11]
        @(posedge sys_clk) disable iff (!rst_n)
        !raw_mode |-> stage_word[4:0] <= 5'h14
    ) else $error("decoded stage two above 10 dB");

    serial_ignored_a: assert property ( // see [R12]
        @(posedge sys_clk) disable iff (!rst_n)
        (!use_serial && $changed(gain_q) && $stable(set_q)
            && $stable(pin_s2_q)) |-> $stable(stage_word)
    ) else $error("serial gain moved the pin-sourced word");

    short_frame_a: assert property ( // see [R14]
        @(posedge sys_clk) disable iff (!rst_n)
        (sen_rise && !pending_q && !new_frame)
            |=> $stable(set_q) && $stable(gain_q)
    ) else $error("frame without a full word was stored");

endmodule

// File: verilog/vgsd_pkg.sv
// Constants shared by the gain-select register bank and its helpers
package vgsd_pkg;

    // ========================================================
    // Timing
    localparam int unsigned SYS_CLK_NS  = 100;
    localparam int unsigned DGL_TIME_NS = 200;
    // Least settling time, rounded up to whole cycles
    localparam int unsigned DGL_CYCLES  =
        (DGL_TIME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

    // ========================================================
    // Serial frame layout
    localparam int unsigned FRAME_BITS = 32;
    localparam int unsigned CNT_W      = 6;
    localparam logic [5:0]  LAST_BIT   = 6'h1F;
    localparam logic [5:0]  DONE_CNT   = 6'h20;
    localparam int unsigned DATA_MSB   = 31;
    localparam int unsigned DATA_LSB   = 8;
    localparam int unsigned ADDR_MSB   = 7;
    localparam int unsigned ADDR_LSB   = 3;
    localparam logic [2:0]  CHIP_ID    = 3'h6;

    // ========================================================
    // Register offsets
    localparam logic [4:0] REG_CTL  = 5'h00;
    localparam logic [4:0] REG_SET  = 5'h02;
    localparam logic [4:0] REG_GAIN = 5'h03;

    // ========================================================
    // Fields and reset values
    localparam int unsigned CTL_W        = 6;
    localparam int unsigned CTL_SRST_BIT = 5;
    localparam logic [5:0]  CTL_DEFAULT  = 6'h00;
    localparam int unsigned SET_W        = 8;
    localparam logic [7:0]  SET_DEFAULT  = 8'h15;
    localparam int unsigned SET_OPAMP_LSB = 0;
    localparam int unsigned SET_DRVR_LSB = 2;
    localparam int unsigned SET_RIN_BIT  = 4;
    localparam int unsigned SET_SRC_BIT  = 5;
    localparam int unsigned SET_RAW_BIT  = 6;
    localparam int unsigned SET_DGL_BIT  = 7;
    localparam int unsigned GAIN_W       = 9;
    localparam logic [8:0]  GAIN_DEFAULT = 9'h000;
    localparam int unsigned CODE_W       = 7;

    // ========================================================
    // Stage word: {stage3, stage1[2:0], stage2[4:0]}
    localparam int unsigned RAW_S3_BIT   = 8;
    localparam int unsigned RAW_S1_LSB   = 5;
    localparam logic [6:0]  CODE_MAX     = 7'h50;
    localparam logic [6:0]  CODE_TIER1   = 7'h14;
    localparam logic [6:0]  CODE_TIER2   = 7'h28;
    localparam logic [6:0]  CODE_TIER3   = 7'h3C;
    localparam logic [2:0]  S1_0DB       = 3'h1;
    localparam logic [2:0]  S1_10DB      = 3'h2;
    localparam logic [2:0]  S1_20DB      = 3'h4;
    localparam logic [8:0]  STAGE_RESET  = 9'h020;

endpackage

// File: verilog/vgsd_gain_decoder.sv
// Maps a 0.5 dB gain code onto the three amplifier stages
module vgsd_gain_decoder
    import vgsd_pkg::*;
(
    input  wire logic [6:0] code,
    output logic      [8:0] stage_word
);

    // ========================================================
    // Allocation
    // Stage 2 takes the remainder so every code step is 0.5 dB
    function automatic logic [8:0] vgsd_decode(input logic [6:0] c);
        logic [6:0] k;
        logic [6:0] r;
        k = (c > CODE_MAX) ? CODE_MAX : c;
        if (k >= CODE_TIER3) begin
            r = 7'(k - CODE_TIER3);
            vgsd_decode = {1'b1, S1_20DB, r[4:0]};
        end else if (k >= CODE_TIER2) begin
            r = 7'(k - CODE_TIER2);
            vgsd_decode = {1'b0, S1_20DB, r[4:0]};
        end else if (k >= CODE_TIER1) begin
            r = 7'(k - CODE_TIER1);
            vgsd_decode = {1'b0, S1_10DB, r[4:0]};
        end else begin
            vgsd_decode = {1'b0, S1_0DB, k[4:0]};
        end
    endfunction

    assign stage_word = vgsd_decode(code); // see [R7] see [R13]

endmodule

// File: verilog/vgsd_deglitch.sv
// Holds a new stage word back until it has settled
module vgsd_deglitch
    import vgsd_pkg::*;
#(
    parameter int unsigned WIDTH  = 9,
    parameter int unsigned CYCLES = DGL_CYCLES
)
(
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             bypass,
    input  wire logic [WIDTH-1:0] word_in,
    output logic      [WIDTH-1:0] word_q
);

    logic [WIDTH-1:0] cand_q;
    logic [7:0]       cnt_q;
    wire              moved   = (word_in != cand_q);
    wire              settled = (cnt_q >= 8'(CYCLES - 1));

    // ========================================================
    // Settling filter
    // Skewed pin edges never reach the stages as a false word
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cand_q <= WIDTH'(STAGE_RESET);
            cnt_q  <= 8'h00;
            word_q <= WIDTH'(STAGE_RESET);
        end else if (bypass) begin // see [R6]
            cand_q <= word_in;
            cnt_q  <= 8'h00;
            word_q <= word_in;
        end else if (moved) begin
            cand_q <= word_in;
            cnt_q  <= 8'h00;
        end else if (settled) begin
            word_q <= cand_q;
        end else begin
            cnt_q  <= cnt_q + 8'h01;
        end
    end

endmodule

// File: test/vgsd_host_model.sv
// Host controller model: drives serial frames and reads back sdo
module vgsd_host_model (
    output logic sck,
    output logic serial_select_n,
    output logic sdi,
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // ============================================================
    // Idle state
    // Link clock stands still low between frames
    initial begin
        sck             = 1'b0;
        serial_select_n = 1'b1;
        sdi             = 1'b0;
    end

    // ============================================================
    // One frame, 80 ns link clock, data moved on the falling edge
    task automatic frame(input logic [23:0] data, input logic [4:0] addr,
                         input logic [2:0] chip, input int nbits,
                         output logic [31:0] seen);
        logic [31:0] word;
        word = {data, addr, chip};
        seen = 32'h0000_0000;
        serial_select_n = 1'b0;
        for (int k = 0; k < nbits; k++) begin
            sdi = word[31-k];
            #40 sck = 1'b1;
            #40 sck = 1'b0;
            seen[31-k] = sdo;
        end
        #10 serial_select_n = 1'b1;
        // Released line shows the inverse, never a stale bit
        sdi = ~sdi;
        // Gap covers the select synchroniser and the commit
        #1000;
    endtask
endmodule

// File: test/vgsd_top_tb.sv
// Self-checking bench for the gain-select register bank
module vgsd_top_tb
    import vgsd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       sys_clk, rst_n, sck, serial_select_n, sdi, sdo, sdo_oe;
    logic       low_imp, stage3_on;
    logic [6:0] pins;
    logic [1:0] opamp_bias, driver_bias;
    logic [2:0] stage1_sel;
    logic [4:0] stage2_step;
    int         miscompares, check_count;

    vgsd_top u_vgsd_top (
        .sys_clk                    (sys_clk),
        .rst_n                      (rst_n),
        .sck                        (sck),
        .serial_select_n            (serial_select_n),
        .sdi                        (sdi),
        .sdo                        (sdo),
        .sdo_oe                     (sdo_oe),
        .parallel_level_pins        (pins),
        .opamp_bias                 (opamp_bias),
        .driver_bias                (driver_bias),
        .low_input_impedance_choice (low_imp),
        .stage1_sel                 (stage1_sel),
        .stage2_step                (stage2_step),
        .stage3_on                  (stage3_on)
    );

    vgsd_host_model u_vgsd_host_model (
        .sck             (sck),
        .serial_select_n (serial_select_n),
        .sdi             (sdi),
        .sdo             (sdo),
        .sdo_oe          (sdo_oe)
    );

    always #50 sys_clk = ~sys_clk;

    // ============================================================
    // Helpers
    task automatic check_word(input string what, input logic [23:0] exp,
                              input logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic check_stage(input string what, input logic [8:0] exp);
        check_word(what, {15'h0, exp},
                   {15'h0, stage3_on, stage1_sel, stage2_step});
    endtask

    task automatic check_set(input logic [4:0] exp);
        check_word("settings pins", {19'h0, exp},
                   {19'h0, low_imp, driver_bias, opamp_bias});
    endtask

    // Three tiers of 20 half-dB steps, then stage three adds 10 dB
    function automatic logic [8:0] exp_dec(input logic [6:0] code);
        if (code < 7'h14) return {1'b0, 3'h1, code[4:0]};
        if (code < 7'h28) return {1'b0, 3'h2, 5'(code - 7'h14)};
        if (code < 7'h3C) return {1'b0, 3'h4, 5'(code - 7'h28)};
        return {1'b1, 3'h4, 5'(code - 7'h3C)};
    endfunction

    task automatic wr(input logic [4:0] addr, input logic [23:0] data);
        logic [31:0] seen;
        u_vgsd_host_model.frame(data, addr, CHIP_ID, 32, seen);
    endtask

    // Point the read address, then a second frame rewrites it and reads
    task automatic rd(input logic [4:0] addr, output logic [23:0] data);
        logic [31:0] seen;
        wr(REG_CTL, {19'h0, addr});
        fork
            u_vgsd_host_model.frame({19'h0, addr}, REG_CTL, CHIP_ID, 32,
                                    seen);
            begin
                #500;
                check_word("sdo_oe", 24'h1, {23'h0, sdo_oe});
            end
        join
        check_word("read tail", {16'h0000, addr, CHIP_ID},
                   {16'h0000, seen[7:0]});
        data = seen[31:8];
    endtask

    task automatic set_pins(input logic [6:0] code, input int settle);
        @(negedge sys_clk) pins = code;
        repeat (settle) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    // ============================================================
    // Scenarios
    task automatic t_reset;
        logic [23:0] v;
        check_word("sdo_oe idle", 24'h0, {23'h0, sdo_oe});
        check_set(5'h15);
        check_stage("reset stage", 9'h020);
        rd(REG_SET, v);
        check_word("settings reset", 24'h000015, v);
        rd(REG_GAIN, v);
        check_word("gain reset", 24'h000000, v);
    endtask

    task automatic t_pin_decode;
        logic [6:0] codes[10] = '{7'h00, 7'h0D, 7'h13, 7'h14, 7'h27,
                                  7'h28, 7'h3B, 7'h3C, 7'h4F, 7'h50};
        foreach (codes[i]) begin
            set_pins(codes[i], 8);
            check_stage("pin code", exp_dec(codes[i]));
        end
        // Codes above the maximum clamp to 40 dB
        set_pins(7'h7F, 8);
        check_stage("pin clamp", exp_dec(7'h50));
        wr(REG_SET, 24'h000055);
        wr(REG_GAIN, 24'h0001FF);
        check_stage("pins over serial", exp_dec(7'h50));
    endtask

    task automatic t_deglitch;
        wr(REG_SET, 24'h000015);
        set_pins(7'h0A, 3);
        check_stage("held by deglitch", exp_dec(7'h50));
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        check_stage("after deglitch", exp_dec(7'h0A));
        wr(REG_SET, 24'h000095);
        set_pins(7'h1E, 3);
        check_stage("deglitch bypass", exp_dec(7'h1E));
    endtask

    task automatic t_settings;
        logic [23:0] v;
        wr(REG_SET, 24'hFFFF8A);
        check_set(5'h0A);
        rd(REG_SET, v);
        check_word("settings unused", 24'h00008A, v);
    endtask

    task automatic t_raw;
        logic [8:0] raws[4] = '{9'h133, 9'h054, 9'h180, 9'h020};
        wr(REG_SET, 24'h0000F5);
        foreach (raws[i]) begin
            wr(REG_GAIN, {15'h0, raws[i]});
            check_stage("raw gain", raws[i]);
        end
    endtask

    task automatic t_decoded;
        logic [23:0] v;
        wr(REG_SET, 24'h0000B5);
        wr(REG_GAIN, 24'hFFF1AD);
        check_stage("decoded gain", exp_dec(7'h2D));
        rd(REG_GAIN, v);
        check_word("gain unused", 24'h0001AD, v);
        wr(REG_GAIN, 24'h000050);
        check_stage("decoded max", exp_dec(7'h50));
    endtask

    task automatic t_refused;
        logic [31:0] seen;
        logic [23:0] v;
        u_vgsd_host_model.frame(24'h000013, REG_GAIN, 3'h5, 32, seen);
        check_stage("wrong chip", exp_dec(7'h50));
        u_vgsd_host_model.frame(24'h000013, REG_GAIN, CHIP_ID, 31, seen);
        check_stage("short frame", exp_dec(7'h50));
        rd(5'h05, v);
        check_word("unmapped read", 24'h000000, v);
    endtask

    task automatic t_soft_reset;
        logic [23:0] v;
        wr(REG_CTL, 24'h000020);
        wr(REG_CTL, 24'h000000);
        check_set(5'h15);
        check_stage("soft reset stage", exp_dec(7'h1E));
        rd(REG_GAIN, v);
        check_word("soft reset gain", 24'h000000, v);
    endtask

    task automatic print_verdict;
        $display("checks %0d, miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ============================================================
    // Main sequence
    initial begin
        sys_clk     = 1'b0;
        rst_n       = 1'b0;
        pins        = 7'h00;
        miscompares = 0;
        check_count = 0;
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        #13;
        t_reset();
        t_pin_decode();
        t_deglitch();
        t_settings();
        t_raw();
        t_decoded();
        t_refused();
        t_soft_reset();
        print_verdict();
    end

    // Hang guard, far beyond the longest expected run
    initial begin
        #3000000;
        miscompares++;
        print_verdict();
    end
endmodule
